// file: src/clock_reset_regs.vh
/*
  Offsets, fields, reset values and counts for clock and reset control.
  Assumes a register port with byte addresses and 32-bit data.
*/
`ifndef CLOCK_RESET_REGS_VH
`define CLOCK_RESET_REGS_VH

// ****************
// Register offsets
// ****************
`define CRC_ADDR_WIDTH        8
`define CRC_OFF_CONTROL       8'h00
`define CRC_OFF_CONFIG        8'h04
`define CRC_OFF_STATUS        8'h08

// ****************
// Control register fields
// ****************
`define CRC_BIT_LOCK_LOSS_DIS 3
`define CRC_BIT_MULT_LOCK     4
`define CRC_BIT_LPM_LOCK      5
`define CRC_BIT_TB_SEL        6
`define CRC_BIT_RTC_DIV       7
`define CRC_BIT_BACKUP_REQ    8
`define CRC_BIT_PWR_REQ_EN    10

// ****************
// Configuration register fields
// ****************
`define CRC_MF_LSB            0
`define CRC_MF_W              4
`define CRC_PREDIVIDER_FIELD_LSB          4
`define CRC_PREDIVIDER_FIELD_W            4
`define CRC_LPM_LSB           8
`define CRC_LPM_W             2
`define CRC_BIT_CLOCK_SOURCE_FIELD          10
`define CRC_BIT_LIMP_EN       11
`define CRC_LOW_FREQ_DIVIDER_LSB          12
`define CRC_DFN_W             3
`define CRC_HIGH_FREQ_DIVIDER_LSB          16

// ****************
// Status register fields
// ****************
`define CRC_BIT_ST_LOCK       0
`define CRC_BIT_ST_HARD_RESET_LINE     1
`define CRC_BIT_ST_BACKUP     2
`define CRC_BIT_ST_FREQ_HIGH  3

// ****************
// Reset values and codes
// ****************
`define CRC_MF_RESET          4'h1
`define CRC_PREDIVIDER_FIELD_RESET        4'h0
`define CRC_LPM_NORMAL_HIGH   2'h0
`define CRC_LOW_FREQ_DIVIDER_RESET        3'h1
`define CRC_HIGH_FREQ_DIVIDER_RESET        3'h0

// ****************
// Divider terminal counts (divide ratio minus one)
// ****************
`define CRC_DIV_WIDTH         8
`define CRC_TERM_DIV4         8'h03
`define CRC_TERM_DIV16        8'h0f
`define CRC_TERM_DIV256       8'hff

// ****************
// Hard reset pulse length in clock cycles
// ****************
`define CRC_HARD_RESET_LINE_CYCLES     16

`endif

// file: src/tick_divider.v
/*
  Tick divider: one pulse per terminal+1 source ticks.
  Assumes one-cycle source ticks synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
  parameter WIDTH = 8
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             src_tick,
  input  wire [WIDTH-1:0] terminal,
  output reg              tick
);

  reg [WIDTH-1:0] count;

  // ****************
  // Counter
  // ****************
  // Terminal may shrink mid-count, so compare with >= to avoid a long wrap
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end else if (src_tick) begin
      if (count >= terminal) begin
        count <= {WIDTH{1'b0}};
        tick  <= 1'b1;
      end else begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        tick  <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: src/reset_stretcher.v
/*
  Stretches a reset request into a fixed-length pulse; retriggerable.
  Assumes the request is synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module reset_stretcher #(
  parameter CYCLES = 16,
  parameter WIDTH  = 8
) (
  input  wire clock,
  input  wire rst,
  input  wire trigger,
  output reg  active
);

  localparam [WIDTH-1:0] LOAD = CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};

  reg [WIDTH-1:0] remain;

  // ****************
  // Pulse counter
  // ****************
  // Retrigger wins so a persistent fault keeps reset asserted
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      remain <= {WIDTH{1'b0}};
      active <= 1'b0;
    end else if (trigger) begin
      remain <= LOAD;
      active <= 1'b1;
    end else if (remain != {WIDTH{1'b0}}) begin
      remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
      active <= 1'b1;
    end else begin
      active <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: src/system_clock_reset_control.v
/*
  Clock and reset control: lock bits, backup clock, hard reset, dividers
  and power-management frequency, behind a plain register port.
  Assumes inputs synchronous to CLOCK, RST as power-on reset and
  oscillator edges as the one-cycle enable OSC_TICK.
*/
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_reset_regs.vh"

// How it works
// - Lock loss during hard reset moves clock to backup when allowed and limp enabled.
// - With switch-disable set, no lock-loss switching; hard reset held until PLL locks.
// - Multiplier lock set blocks writes to multiplier and pre-divider fields.
// - Multiplier or pre-divider change while low-power lock set forces hard reset.
// - Multiplier lock bit takes one write per power-on reset only.
// - Low-power lock set blocks writes to low-power mode and clock-source fields.
// - Low-power lock set and mode not normal-high forces hard reset.
// - Low-power lock bit takes one write per power-on reset only.
// - Time-base source: oscillator over 4 or 16, or system clock over 16.
// - RTC and timer clock divided by 4 or by 256.
// - Power-on reset clears RTC divider bit if straps 1-3 low, else sets.
// - Setting backup switch bit moves clock to ring oscillator and hard resets.
// - Backup switch bit ignored while limp enable is clear.
// - Request enable clear keeps low-frequency divider regardless of requests.
// - Request enable set selects high divider on power bit clear or interrupt.
module system_clock_reset_control #(
  parameter HARD_RESET_LINE_CYCLES = `CRC_HARD_RESET_LINE_CYCLES
) (
  input  wire                       CLOCK,
  input  wire                       RST,
  input  wire [`CRC_ADDR_WIDTH-1:0] ADDR,
  input  wire [31:0]                WRITE_DATA,
  input  wire                       WRITE_STROBE,
  input  wire                       READ_STROBE,
  output reg  [31:0]                READ_DATA,
  input  wire [2:0]                 CLOCK_MODE_STRAPS,
  input  wire                       PLL_LOCKED,
  input  wire                       HARD_RESET_IN,
  input  wire                       POWER_MGMT_STATE_BIT,
  input  wire                       INTERRUPT_PENDING,
  input  wire                       OSC_TICK,
  input  wire                       TB_OSC_DIV16,
  output reg                        HARD_RESET_LINE,
  output reg                        USE_BACKUP_CLOCK,
  output reg                        FREQ_HIGH,
  output reg  [`CRC_DFN_W-1:0]      FREQ_DIVIDER,
  output reg  [`CRC_MF_W-1:0]       FREQ_MULTIPLIER,
  output reg  [`CRC_PREDIVIDER_FIELD_W-1:0]     PREDIVIDER,
  output reg  [`CRC_LPM_W-1:0]      LOWPOWER_MODE,
  output reg                        CLOCK_SOURCE,
  output wire                       TIMEBASE_TICK,
  output wire                       RTC_PIT_TICK
);

  // ****************************************
  // Register state
  // ****************************************
  reg                     lock_loss_switch_disable;
  reg                     multiplier_divider_lock;
  reg                     lowpower_mode_lock;
  reg                     timebase_source_sel;
  reg                     rtc_pit_divider_sel;
  reg                     power_request_enable;
  reg                     limp_enable;
  reg  [`CRC_DFN_W-1:0]   low_freq_divider;
  reg  [`CRC_DFN_W-1:0]   high_freq_divider;
  reg                     mult_lock_written;
  reg                     lpm_lock_written;
  reg                     straps_taken;
  reg                     reset_trigger;

  wire                    write_control;
  wire                    write_config;
  wire                    backup_request;
  wire                    lock_loss_switch;
  wire                    reset_hold;
  wire                    stretch_active;
  wire [`CRC_MF_W-1:0]    next_mult;
  wire [`CRC_PREDIVIDER_FIELD_W-1:0]  next_prediv;
  wire [`CRC_LPM_W-1:0]   next_lpm;
  wire                    next_clock_source_field;
  wire                    mult_change;
  wire                    mode_violation;
  wire                    next_freq_high;
  wire [`CRC_DIV_WIDTH-1:0] tb_terminal;
  wire [`CRC_DIV_WIDTH-1:0] rtc_terminal;
  wire                    tb_source;

  // ****************************************
  // Write decode
  // ****************************************
  assign write_control = WRITE_STROBE && (ADDR == `CRC_OFF_CONTROL);
  assign write_config  = WRITE_STROBE && (ADDR == `CRC_OFF_CONFIG);

  // Software backup request only counts while limp mode is enabled
  assign backup_request = write_control && WRITE_DATA[`CRC_BIT_BACKUP_REQ]
                          && limp_enable;

  // Lock loss inside hard reset switches only when not disabled
  assign lock_loss_switch = !lock_loss_switch_disable && limp_enable
                            && HARD_RESET_IN && !PLL_LOCKED;

  // Disabled switching instead holds hard reset until the PLL locks
  assign reset_hold = lock_loss_switch_disable && HARD_RESET_IN
                      && !PLL_LOCKED;

  // ****************************************
  // Locked field next values
  // ****************************************
  // Multiplier and pre-divider pass only while their lock is clear
  assign next_mult = (write_config && !multiplier_divider_lock) ?
                     WRITE_DATA[`CRC_MF_LSB +: `CRC_MF_W] : FREQ_MULTIPLIER;
  assign next_prediv = (write_config && !multiplier_divider_lock) ?
                       WRITE_DATA[`CRC_PREDIVIDER_FIELD_LSB +: `CRC_PREDIVIDER_FIELD_W] : PREDIVIDER;

  // Mode and clock source pass only while the low-power lock is clear
  assign next_lpm = (write_config && !lowpower_mode_lock) ?
                    WRITE_DATA[`CRC_LPM_LSB +: `CRC_LPM_W] : LOWPOWER_MODE;
  assign next_clock_source_field = (write_config && !lowpower_mode_lock) ?
                     WRITE_DATA[`CRC_BIT_CLOCK_SOURCE_FIELD] : CLOCK_SOURCE;

  // A frequency change under the low-power lock is treated as interference
  assign mult_change = lowpower_mode_lock &&
                       ((next_mult != FREQ_MULTIPLIER) ||
                        (next_prediv != PREDIVIDER));

  // Any mode other than normal-high is illegal under the low-power lock
  assign mode_violation = lowpower_mode_lock &&
                          (LOWPOWER_MODE != `CRC_LPM_NORMAL_HIGH);

  // ****************************************
  // Control register
  // ****************************************
  // Any control write spends the one-shot lock chance, even writing zero
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      lock_loss_switch_disable <= 1'b0;
      multiplier_divider_lock  <= 1'b0;
      lowpower_mode_lock       <= 1'b0;
      timebase_source_sel      <= 1'b0;
      power_request_enable     <= 1'b0;
      mult_lock_written        <= 1'b0;
      lpm_lock_written         <= 1'b0;
    end else if (write_control) begin
      lock_loss_switch_disable <= WRITE_DATA[`CRC_BIT_LOCK_LOSS_DIS];
      timebase_source_sel      <= WRITE_DATA[`CRC_BIT_TB_SEL];
      power_request_enable     <= WRITE_DATA[`CRC_BIT_PWR_REQ_EN];
      mult_lock_written        <= 1'b1;
      lpm_lock_written         <= 1'b1;
      if (!mult_lock_written) begin
        multiplier_divider_lock <= WRITE_DATA[`CRC_BIT_MULT_LOCK];
      end
      if (!lpm_lock_written) begin
        lowpower_mode_lock <= WRITE_DATA[`CRC_BIT_LPM_LOCK];
      end
    end
  end

  // ****************************************
  // RTC divider bit and strap capture
  // ****************************************
  // Straps are sampled on the first edge after power-on reset release,
  // since an asynchronous reset may only load a constant
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rtc_pit_divider_sel <= 1'b1;
      straps_taken        <= 1'b0;
    end else if (!straps_taken) begin
      rtc_pit_divider_sel <= |CLOCK_MODE_STRAPS;
      straps_taken        <= 1'b1;
    end else if (write_control) begin
      rtc_pit_divider_sel <= WRITE_DATA[`CRC_BIT_RTC_DIV];
    end
  end

  // ****************************************
  // Configuration register
  // ****************************************
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      FREQ_MULTIPLIER   <= `CRC_MF_RESET;
      PREDIVIDER        <= `CRC_PREDIVIDER_FIELD_RESET;
      LOWPOWER_MODE     <= `CRC_LPM_NORMAL_HIGH;
      CLOCK_SOURCE      <= 1'b0;
      limp_enable       <= 1'b1;
      low_freq_divider  <= `CRC_LOW_FREQ_DIVIDER_RESET;
      high_freq_divider <= `CRC_HIGH_FREQ_DIVIDER_RESET;
    end else begin
      FREQ_MULTIPLIER <= next_mult;
      PREDIVIDER      <= next_prediv;
      LOWPOWER_MODE   <= next_lpm;
      CLOCK_SOURCE    <= next_clock_source_field;
      if (write_config) begin
        limp_enable       <= WRITE_DATA[`CRC_BIT_LIMP_EN];
        low_freq_divider  <= WRITE_DATA[`CRC_LOW_FREQ_DIVIDER_LSB +: `CRC_DFN_W];
        high_freq_divider <= WRITE_DATA[`CRC_HIGH_FREQ_DIVIDER_LSB +: `CRC_DFN_W];
      end
    end
  end

  // ****************************************
  // Backup clock and hard reset
  // ****************************************
  // Backup selection sticks until power-on reset, even after relock
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      USE_BACKUP_CLOCK <= 1'b0;
      reset_trigger    <= 1'b0;
      HARD_RESET_LINE  <= 1'b0;
    end else begin
      USE_BACKUP_CLOCK <= USE_BACKUP_CLOCK || lock_loss_switch
                          || backup_request;
      reset_trigger    <= backup_request
                          || mult_change
                          || mode_violation;
      HARD_RESET_LINE  <= stretch_active || reset_hold;
    end
  end

  reset_stretcher #(
    .CYCLES (HARD_RESET_LINE_CYCLES),
    .WIDTH  (16)
  ) u_reset_stretcher (
    .clock   (CLOCK),
    .rst     (RST),
    .trigger (reset_trigger),
    .active  (stretch_active)
  );

  // ****************************************
  // Power-management frequency selection
  // ****************************************
  // Requests are honoured only with the enable set; otherwise stay low
  assign next_freq_high = power_request_enable
                          && (!POWER_MGMT_STATE_BIT || INTERRUPT_PENDING);

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      FREQ_HIGH    <= 1'b0;
      FREQ_DIVIDER <= `CRC_LOW_FREQ_DIVIDER_RESET;
    end else begin
      FREQ_HIGH    <= next_freq_high;
      FREQ_DIVIDER <= next_freq_high ? high_freq_divider : low_freq_divider;
    end
  end

  // ****************************************
  // Time-base and RTC dividers
  // ****************************************
  // System clock source ticks every cycle, oscillator source on its enable
  assign tb_source   = timebase_source_sel ? 1'b1 : OSC_TICK;
  assign tb_terminal = (timebase_source_sel || TB_OSC_DIV16) ?
                       `CRC_TERM_DIV16 : `CRC_TERM_DIV4;
  assign rtc_terminal = rtc_pit_divider_sel ?
                        `CRC_TERM_DIV256 : `CRC_TERM_DIV4;

  tick_divider #(
    .WIDTH (`CRC_DIV_WIDTH)
  ) u_timebase_div (
    .clock    (CLOCK),
    .rst      (RST),
    .src_tick (tb_source),
    .terminal (tb_terminal),
    .tick     (TIMEBASE_TICK)
  );

  tick_divider #(
    .WIDTH (`CRC_DIV_WIDTH)
  ) u_rtc_div (
    .clock    (CLOCK),
    .rst      (RST),
    .src_tick (OSC_TICK),
    .terminal (rtc_terminal),
    .tick     (RTC_PIT_TICK)
  );

  // ****************************************
  // Read port
  // ****************************************
  // Data stands only in the cycle after the strobe; unmapped reads zero
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      READ_DATA <= 32'h00000000;
    end else begin
      READ_DATA <= 32'h00000000;
      if (READ_STROBE) begin
        case (ADDR)
          `CRC_OFF_CONTROL: begin
            READ_DATA[`CRC_BIT_LOCK_LOSS_DIS] <= lock_loss_switch_disable;
            READ_DATA[`CRC_BIT_MULT_LOCK]     <= multiplier_divider_lock;
            READ_DATA[`CRC_BIT_LPM_LOCK]      <= lowpower_mode_lock;
            READ_DATA[`CRC_BIT_TB_SEL]        <= timebase_source_sel;
            READ_DATA[`CRC_BIT_RTC_DIV]       <= rtc_pit_divider_sel;
            READ_DATA[`CRC_BIT_BACKUP_REQ]    <= USE_BACKUP_CLOCK;
            READ_DATA[`CRC_BIT_PWR_REQ_EN]    <= power_request_enable;
          end
          `CRC_OFF_CONFIG: begin
            READ_DATA[`CRC_MF_LSB +: `CRC_MF_W]     <= FREQ_MULTIPLIER;
            READ_DATA[`CRC_PREDIVIDER_FIELD_LSB +: `CRC_PREDIVIDER_FIELD_W] <= PREDIVIDER;
            READ_DATA[`CRC_LPM_LSB +: `CRC_LPM_W]   <= LOWPOWER_MODE;
            READ_DATA[`CRC_BIT_CLOCK_SOURCE_FIELD]                <= CLOCK_SOURCE;
            READ_DATA[`CRC_BIT_LIMP_EN]             <= limp_enable;
            READ_DATA[`CRC_LOW_FREQ_DIVIDER_LSB +: `CRC_DFN_W]  <= low_freq_divider;
            READ_DATA[`CRC_HIGH_FREQ_DIVIDER_LSB +: `CRC_DFN_W]  <= high_freq_divider;
          end
          `CRC_OFF_STATUS: begin
            READ_DATA[`CRC_BIT_ST_LOCK]      <= PLL_LOCKED;
            READ_DATA[`CRC_BIT_ST_HARD_RESET_LINE]    <= HARD_RESET_LINE;
            READ_DATA[`CRC_BIT_ST_BACKUP]    <= USE_BACKUP_CLOCK;
            READ_DATA[`CRC_BIT_ST_FREQ_HIGH] <= FREQ_HIGH;
          end
          default: begin
            READ_DATA <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/system_clock_reset_control_asserts.sv
/*
  Concurrent checks on the clock and reset control block.
  Assumes a bind onto system_clock_reset_control; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_reset_regs.vh"

module clock_reset_checker #(
  parameter HARD_RESET_LINE_CYCLES = 16
) (
  input wire logic                       CLOCK,
  input wire logic                       RST,
  input wire logic [`CRC_ADDR_WIDTH-1:0] ADDR,
  input wire logic [31:0]                WRITE_DATA,
  input wire logic                       WRITE_STROBE,
  input wire logic                       PLL_LOCKED,
  input wire logic                       HARD_RESET_IN,
  input wire logic                       POWER_MGMT_STATE_BIT,
  input wire logic                       INTERRUPT_PENDING,
  input wire logic                       HARD_RESET_LINE,
  input wire logic                       USE_BACKUP_CLOCK,
  input wire logic                       FREQ_HIGH,
  input wire logic [`CRC_MF_W-1:0]       FREQ_MULTIPLIER,
  input wire logic [`CRC_PREDIVIDER_FIELD_W-1:0]     PREDIVIDER,
  input wire logic [`CRC_LPM_W-1:0]      LOWPOWER_MODE,
  input wire logic                       CLOCK_SOURCE
);
  // ****************
  // Shadow bits
  // ****************
  wire        ctrl_wr = WRITE_STROBE && ADDR == `CRC_OFF_CONTROL;
  wire        cfg_wr  = WRITE_STROBE && ADDR == `CRC_OFF_CONFIG;
  logic       spent, mlock, llock, sw_dis, pwr_en, limp;
  logic [7:0] run;

  // Locks follow only the first control write; run counts hard reset cycles
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      spent <= 1'b0;
      mlock <= 1'b0;
      llock <= 1'b0;
      sw_dis <= 1'b0;
      pwr_en <= 1'b0;
      limp <= 1'b1;
      run <= 8'h00;
    end else begin
      run <= HARD_RESET_LINE ? run + 8'h01 : 8'h00;
      if (ctrl_wr) begin
        spent <= 1'b1;
        sw_dis <= WRITE_DATA[`CRC_BIT_LOCK_LOSS_DIS];
        pwr_en <= WRITE_DATA[`CRC_BIT_PWR_REQ_EN];
        if (!spent) begin
          mlock <= WRITE_DATA[`CRC_BIT_MULT_LOCK];
          llock <= WRITE_DATA[`CRC_BIT_LPM_LOCK];
        end
      end
      if (cfg_wr) begin
        limp <= WRITE_DATA[`CRC_BIT_LIMP_EN];
      end
    end
  end

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_req;
    ctrl_wr && WRITE_DATA[`CRC_BIT_BACKUP_REQ];
  endsequence
  sequence s_switch_then_reset;
    USE_BACKUP_CLOCK ##2 HARD_RESET_LINE [*2];
  endsequence
  property p_backup_switch;
    s_req and limp |=> s_switch_then_reset;
  endproperty
  a_backup_switch: assert property (p_backup_switch) else $error("backup switch missed");
  property p_reset_len;
    $fell(HARD_RESET_LINE) && !$past(HARD_RESET_IN) |-> run >= HARD_RESET_LINE_CYCLES;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("hard reset too short");
  property p_backup_ignored;
    s_req and !limp |=> $stable(USE_BACKUP_CLOCK);
  endproperty
  a_backup_ignored: assert property (p_backup_ignored) else $error("switch without limp");
  property p_loss_switch;
    !sw_dis && limp && HARD_RESET_IN && !PLL_LOCKED |=> USE_BACKUP_CLOCK;
  endproperty
  a_loss_switch: assert property (p_loss_switch) else $error("no switch on lock loss");
  property p_loss_hold;
    sw_dis && HARD_RESET_IN && !PLL_LOCKED |=> HARD_RESET_LINE;
  endproperty
  a_loss_hold: assert property (p_loss_hold) else $error("hard reset not held");
  property p_mult_locked;
    mlock && $past(mlock) |-> $stable(FREQ_MULTIPLIER) && $stable(PREDIVIDER);
  endproperty
  a_mult_locked: assert property (p_mult_locked) else $error("locked multiplier moved");
  property p_lpm_locked;
    llock && $past(llock) |-> $stable(LOWPOWER_MODE) && $stable(CLOCK_SOURCE);
  endproperty
  a_lpm_locked: assert property (p_lpm_locked) else $error("locked mode moved");
  property p_mode_reset;
    llock && LOWPOWER_MODE != `CRC_LPM_NORMAL_HIGH |-> ##[1:3] HARD_RESET_LINE;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode change not reset");
  property p_mult_reset;
    $changed(FREQ_MULTIPLIER) && $past(llock) |-> ##[0:3] HARD_RESET_LINE;
  endproperty
  a_mult_reset: assert property (p_mult_reset) else $error("multiplier change not reset");
  property p_freq_low;
    !$past(pwr_en) |-> !FREQ_HIGH;
  endproperty
  a_freq_low: assert property (p_freq_low) else $error("high frequency while disabled");
  property p_freq_high;
    $past(pwr_en) |-> FREQ_HIGH == $past(!POWER_MGMT_STATE_BIT || INTERRUPT_PENDING);
  endproperty
  a_freq_high: assert property (p_freq_high) else $error("frequency select wrong");
endmodule

bind system_clock_reset_control clock_reset_checker #(.HARD_RESET_LINE_CYCLES(HARD_RESET_LINE_CYCLES)) chk (.*);
`default_nettype wire

// file: tb/system_clock_reset_control_bench.sv
/*
  Self-checking bench for the clock and reset control block.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_reset_regs.vh"

module system_clock_reset_control_bench;
  localparam int HRC = 8;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WRITE_DATA = 32'h0;
  logic        WRITE_STROBE = 1'b0;
  logic        READ_STROBE = 1'b0;
  logic [2:0]  CLOCK_MODE_STRAPS = 3'h0;
  logic        PLL_LOCKED = 1'b1;
  logic        HARD_RESET_IN = 1'b0;
  logic        POWER_MGMT_STATE_BIT = 1'b0;
  logic        INTERRUPT_PENDING = 1'b0;
  logic        OSC_TICK = 1'b0;
  logic        TB_OSC_DIV16 = 1'b0;
  logic [31:0] READ_DATA;
  logic        HARD_RESET_LINE, USE_BACKUP_CLOCK, FREQ_HIGH, CLOCK_SOURCE;
  logic        TIMEBASE_TICK, RTC_PIT_TICK;
  logic [2:0]  FREQ_DIVIDER;
  logic [3:0]  FREQ_MULTIPLIER, PREDIVIDER;
  logic [1:0]  LOWPOWER_MODE;
  int          err_count = 0;
  int          checks = 0;

  system_clock_reset_control #(.HARD_RESET_LINE_CYCLES(HRC)) dut (.*);

  // 100 MHz clock; oscillator edge stands every second cycle
  always #5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) OSC_TICK <= ~OSC_TICK;

  // ****************
  // Helpers
  // ****************
  task conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (checks > 0 && err_count == 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Bus tasks end one idle edge after the strobe
  task wr(input logic [7:0] a, input logic [31:0] d);
    ADDR <= a;
    WRITE_DATA <= d;
    WRITE_STROBE <= 1'b1;
    @(posedge CLOCK);
    WRITE_STROBE <= 1'b0;
    @(posedge CLOCK);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    ADDR <= a;
    READ_STROBE <= 1'b1;
    @(posedge CLOCK);
    READ_STROBE <= 1'b0;
    #1 check(READ_DATA, exp);
    @(posedge CLOCK);
  endtask

  task do_reset(input logic [2:0] straps);
    RST <= 1'b1;
    CLOCK_MODE_STRAPS <= straps;
    PLL_LOCKED <= 1'b1;
    HARD_RESET_IN <= 1'b0;
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    repeat (2) @(posedge CLOCK);
  endtask

  // Bounded wait for a level on backup select or hard reset
  task automatic wait_on(input bit backup, input logic lvl, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge CLOCK);
      #1;
      if ((backup ? USE_BACKUP_CLOCK : HARD_RESET_LINE) === lvl) break;
    end
    check(k < n, 32'h1);
    if (k >= n) conclude;
    @(posedge CLOCK);
  endtask

  // Gap from second to third tick; the first gap may be partial
  task automatic tick_gap(input bit tb, input int exp);
    int n, k, last;
    k = 0;
    last = 0;
    for (n = 0; n < 2100 && k < 3; n++) begin
      @(posedge CLOCK);
      #1;
      if ((tb ? TIMEBASE_TICK : RTC_PIT_TICK) === 1'b1) begin
        k++;
        if (k == 3) check(n - last, exp);
        last = n;
      end
    end
    if (k < 3) begin
      check(k, 3);
      conclude;
    end
    @(posedge CLOCK);
  endtask

  // ****************
  // Scenarios
  // ****************
  task sc_reset_values;
    do_reset(3'h0);
    rd(`CRC_OFF_CONTROL, 32'h0);
    rd(`CRC_OFF_CONFIG, 32'h0000_1801);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0);
    wr(`CRC_OFF_STATUS, 32'h0);
    rd(`CRC_OFF_STATUS, 32'h1);
    do_reset(3'h4);
    rd(`CRC_OFF_CONTROL, 32'h80);
  endtask

  task sc_ticks;
    do_reset(3'h0);
    tick_gap(1, 8);
    tick_gap(0, 8);
    TB_OSC_DIV16 <= 1'b1;
    tick_gap(1, 32);
    wr(`CRC_OFF_CONTROL, 32'hc0);
    tick_gap(1, 16);
    tick_gap(0, 512);
  endtask

  // Multiplier lock takes one write only
  task sc_mult_lock;
    do_reset(3'h0);
    wr(`CRC_OFF_CONTROL, 32'h10);
    wr(`CRC_OFF_CONFIG, 32'h0000_18f5);
    rd(`CRC_OFF_CONFIG, 32'h0000_1801);
    wr(`CRC_OFF_CONTROL, 32'h0);
    rd(`CRC_OFF_CONTROL, 32'h10);
    wr(`CRC_OFF_CONFIG, 32'h0000_1f01);
    rd(`CRC_OFF_CONFIG, 32'h0000_1f01);
  endtask

  task sc_lpm_lock;
    do_reset(3'h0);
    wr(`CRC_OFF_CONFIG, 32'h0000_1802);
    rd(`CRC_OFF_CONFIG, 32'h0000_1802);
    wr(`CRC_OFF_CONTROL, 32'h20);
    wr(`CRC_OFF_CONTROL, 32'h0);
    rd(`CRC_OFF_CONTROL, 32'h20);
    wr(`CRC_OFF_CONFIG, 32'h0000_1f02);
    rd(`CRC_OFF_CONFIG, 32'h0000_1802);
    wr(`CRC_OFF_CONFIG, 32'h0000_1803);
    wait_on(0, 1'b1, 4);
    do_reset(3'h0);
    wr(`CRC_OFF_CONFIG, 32'h0000_1901);
    wr(`CRC_OFF_CONTROL, 32'h20);
    wait_on(0, 1'b1, 5);
  endtask

  task automatic sc_backup;
    int n, high;
    do_reset(3'h0);
    wr(`CRC_OFF_CONFIG, 32'h0000_1001);
    wr(`CRC_OFF_CONTROL, 32'h100);
    repeat (20) @(posedge CLOCK);
    #1 check({HARD_RESET_LINE, USE_BACKUP_CLOCK}, 32'h0);
    @(posedge CLOCK);
    wr(`CRC_OFF_CONFIG, 32'h0000_1801);
    wr(`CRC_OFF_CONTROL, 32'h100);
    #1 check(USE_BACKUP_CLOCK, 32'h1);
    high = 0;
    for (n = 0; n < 40; n++) begin
      @(posedge CLOCK);
      #1 high = high + (HARD_RESET_LINE === 1'b1);
    end
    check(high, HRC);
    @(posedge CLOCK);
    rd(`CRC_OFF_STATUS, 32'h5);
  endtask

  task sc_lock_loss;
    do_reset(3'h0);
    wr(`CRC_OFF_CONTROL, 32'h8);
    HARD_RESET_IN <= 1'b1;
    PLL_LOCKED <= 1'b0;
    repeat (30) @(posedge CLOCK);
    #1 check({HARD_RESET_LINE, USE_BACKUP_CLOCK}, 32'h2);
    @(posedge CLOCK);
    PLL_LOCKED <= 1'b1;
    wait_on(0, 1'b0, HRC + 4);
    wr(`CRC_OFF_CONTROL, 32'h0);
    PLL_LOCKED <= 1'b0;
    wait_on(1, 1'b1, 4);
    PLL_LOCKED <= 1'b1;
    HARD_RESET_IN <= 1'b0;
  endtask

  // All enable, power bit and interrupt combinations
  task automatic sc_freq;
    int i;
    logic hi;
    do_reset(3'h0);
    wr(`CRC_OFF_CONFIG, 32'h0005_3801);
    for (i = 0; i < 8; i++) begin
      wr(`CRC_OFF_CONTROL, {21'h0, i[2], 10'h0});
      POWER_MGMT_STATE_BIT <= i[1];
      INTERRUPT_PENDING <= i[0];
      hi = i[2] && (!i[1] || i[0]);
      repeat (2) @(posedge CLOCK);
      #1 check({FREQ_HIGH, FREQ_DIVIDER}, {hi, hi ? 3'h5 : 3'h3});
      @(posedge CLOCK);
    end
  endtask

  // Main sequence
  initial begin
    sc_reset_values;
    sc_ticks;
    sc_mult_lock;
    sc_lpm_lock;
    sc_backup;
    sc_lock_loss;
    sc_freq;
    conclude;
  end
endmodule
`default_nettype wire
